// ### logic/fdp_pkg.sv
package fdp_pkg;

	// ************************************************************
	// register map, byte addresses on the register port
	// ************************************************************
	localparam logic [9:0] ADDR_CTRL = 10'h3f0;
	localparam logic [9:0] ADDR_FIFO = 10'h3f1;
	localparam logic [9:0] ADDR_FCR = 10'h3f2;
	localparam logic [9:0] ADDR_TAPE = 10'h3f3;
	localparam logic [9:0] ADDR_STAT = 10'h3f4;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_DRV = 0;
	localparam int CTRL_PC_LO = 1;
	localparam int CTRL_WR_EN = 3;
	localparam int CTRL_PPM = 4;
	localparam int CTRL_PNF = 5;
	localparam int FCR_MSENSE = 0;
	localparam int TAPE_VLD = 5;
	localparam int TAPE_ID_LO = 6;
	localparam int STAT_WP = 0;
	localparam int STAT_EMPTY = 1;
	localparam int STAT_FULL = 2;
	localparam int STAT_BUSY = 3;
	localparam int STAT_HEAD_AT_FIRST_TRACK = 4;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] TAPE_SEL_RST = 2'h0;
	localparam logic [7:0] RDATA_IDLE = 8'h00;

	// ************************************************************
	// timing: 125 mhz clock, 500 kbit/s cell
	// ************************************************************
	localparam int CLK_NS = 8;
	localparam int BIT_NS = 2000;
	localparam int PULSE_NS = 250;
	localparam int PC_STEP_NS = 125;
	localparam logic [7:0] BIT_CYC = 8'(BIT_NS / CLK_NS);
	localparam logic [7:0] PULSE_CYC = 8'((PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] PC_STEP_CYC = 8'((PC_STEP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] PC_BASE_CYC = 8'(BIT_NS / CLK_NS / 2);
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = 8;

	// ************************************************************
	// pin groups
	// ************************************************************
	typedef struct packed {
		logic wp;
		logic head_at_first_track;
		logic [1:0] media_id;
	} fdp_drv_in_t;

	typedef struct packed {
		logic wp;
		logic head_at_first_track;
	} fdp_alt_in_t;

	typedef struct packed {
		logic wdata;
		logic floppy_write_enable_gate;
		logic step;
	} fdp_drv_out_t;

	typedef enum logic {SER_IDLE, SER_BIT} fdp_ser_t;

endpackage

// ### logic/fdp_fifo.sv
`timescale 1ns/1ps

// ************************************************************
// first-in first-out buffer for write bytes
// ************************************************************
module fdp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// pointers carry one extra bit to tell full from empty
	assign in_ready = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]) || (wr_ptr_r[AW] == rd_ptr_r[AW]);
	assign out_valid = wr_ptr_r != rd_ptr_r;
	assign out_data = mem[rd_ptr_r[AW-1:0]];

	// storage array
	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wr_ptr_r[AW-1:0]] <= in_data;
	end

	// pointer update
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
			rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
		end
	end

endmodule // fdp_fifo

// ### logic/fdp_top.sv
`timescale 1ns/1ps

// How it works
// - strap a low at reset: status bit 5 reads 0 for drive 0
// - strap a high at reset: status bit 5 reads 1 for drive 0
// - strap b decides status bit 5 the same way for drive 1
// - strap a value at the first edge after reset release is loaded into control bit 0
// - with control bit 0 set, the strap-derived bit carries no meaning
// - serial write data leaves with software-selectable precompensation
// - write gate only while writing, glitch free from flop
// - parallel-port-floppy mode with select flag 0 duplicates drive signals
module fdp_top (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [9:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic media_id_valid_strap_a,
	input wire logic media_id_valid_strap_b,
	input wire logic step_req,
	input wire fdp_pkg::fdp_drv_in_t drv_in,
	input wire fdp_pkg::fdp_alt_in_t alt_in,
	output fdp_pkg::fdp_drv_out_t drv_out,
	output fdp_pkg::fdp_drv_out_t alt_out
);

	// ************************************************************
	// state
	// ************************************************************
	logic [7:0] ctrl_r;
	logic [1:0] tape_sel_r;
	logic function_control_reg_r;
	logic strap_a_r;
	logic strap_b_r;
	logic cap_done_r;
	fdp_pkg::fdp_ser_t state_r;
	fdp_pkg::fdp_ser_t state_nxt;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [2:0] bitn_r;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic prev_r;
	logic [7:0] rdata_nxt;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;

	// ************************************************************
	// decode
	// ************************************************************
	// pulse start inside the cell, moved early or late by pattern
	function automatic logic [7:0] pc_start(input logic [1:0] sel, input logic prv, input logic nxt);
		logic [7:0] amt;
		amt = 8'(sel) * fdp_pkg::PC_STEP_CYC;
		if (prv && !nxt)
			pc_start = fdp_pkg::PC_BASE_CYC + amt;
		else if (!prv && nxt)
			pc_start = fdp_pkg::PC_BASE_CYC - amt;
		else
			pc_start = fdp_pkg::PC_BASE_CYC;
	endfunction

	wire wr_ctrl = reg_wr && (reg_addr == fdp_pkg::ADDR_CTRL);
	wire wr_fifo = reg_wr && (reg_addr == fdp_pkg::ADDR_FIFO);
	wire wr_fcr = reg_wr && (reg_addr == fdp_pkg::ADDR_FCR);
	wire wr_tape = reg_wr && (reg_addr == fdp_pkg::ADDR_TAPE);
	wire drv_sel = ctrl_r[fdp_pkg::CTRL_DRV];
	wire [1:0] pc_sel = ctrl_r[fdp_pkg::CTRL_PC_LO +: 2];
	wire wr_en = ctrl_r[fdp_pkg::CTRL_WR_EN];
	wire ppm_en = ctrl_r[fdp_pkg::CTRL_PPM] && !ctrl_r[fdp_pkg::CTRL_PNF];
	wire sel_wp = ppm_en ? alt_in.wp : drv_in.wp;
	wire sel_head_at_first_track = ppm_en ? alt_in.head_at_first_track : drv_in.head_at_first_track;
	wire sel_strap = drv_sel ? strap_b_r : strap_a_r;
	wire vld_bit = function_control_reg_r ? 1'b1 : sel_strap;
	wire cell_end = cnt_r == (fdp_pkg::BIT_CYC - 8'h01);
	wire load = wr_en && fifo_out_valid && !sel_wp && ((state_r == fdp_pkg::SER_IDLE) || (cell_end && bitn_r == 3'h7));
	wire next_bit = (bitn_r == 3'h7) ? 1'b0 : shift_r[6];
	wire [7:0] p_start = pc_start(pc_sel, prev_r, next_bit);
	wire in_pulse = (cnt_r >= p_start) && (cnt_r < p_start + fdp_pkg::PULSE_CYC);
	wire wdata_nxt = (state_r == fdp_pkg::SER_BIT) && shift_r[7] && in_pulse;
	wire floppy_write_enable_gate_nxt = state_nxt == fdp_pkg::SER_BIT;

	wire [7:0] tape_rd = {drv_in.media_id, vld_bit, 3'h0, tape_sel_r};
	wire [7:0] stat_rd = {3'h0, sel_head_at_first_track, state_r == fdp_pkg::SER_BIT, !fifo_in_ready, !fifo_out_valid, sel_wp};

	// read mux, zero for unmapped addresses
	always_comb
	begin
		rdata_nxt = fdp_pkg::RDATA_IDLE;
		if (reg_rd)
		begin
			unique case (reg_addr)
				fdp_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
				fdp_pkg::ADDR_FCR: rdata_nxt = {7'h00, function_control_reg_r};
				fdp_pkg::ADDR_TAPE: rdata_nxt = tape_rd;
				fdp_pkg::ADDR_STAT: rdata_nxt = stat_rd;
				default: rdata_nxt = fdp_pkg::RDATA_IDLE;
			endcase
		end
	end

	// ************************************************************
	// write byte buffer
	// ************************************************************
	fdp_fifo #(
		.WIDTH(fdp_pkg::FIFO_WIDTH),
		.DEPTH(fdp_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.nrst(nrst),
		.in_valid(wr_fifo),
		.in_ready(fifo_in_ready),
		.in_data(reg_wdata),
		.out_valid(fifo_out_valid),
		.out_ready(load),
		.out_data(fifo_out_data)
	);

	// serializer next state
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r + 8'h01;
		shift_nxt = shift_r;
		unique case (state_r)
			fdp_pkg::SER_IDLE:
			begin
				cnt_nxt = 8'h00;
				if (load)
				begin
					state_nxt = fdp_pkg::SER_BIT;
					shift_nxt = fifo_out_data;
				end
			end
			fdp_pkg::SER_BIT:
			begin
				if (cell_end)
				begin
					cnt_nxt = 8'h00;
					shift_nxt = {shift_r[6:0], 1'b0};
					if (bitn_r == 3'h7)
					begin
						if (load)
							shift_nxt = fifo_out_data;
						else
							state_nxt = fdp_pkg::SER_IDLE;
					end
				end
			end
		endcase
	end

	// ************************************************************
	// registers
	// ************************************************************
	// straps caught at the first edge after reset release
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cap_done_r <= 1'b0;
			strap_a_r <= 1'b0;
			strap_b_r <= 1'b0;
			function_control_reg_r <= 1'b0;
		end
		else if (!cap_done_r)
		begin
			cap_done_r <= 1'b1;
			strap_a_r <= media_id_valid_strap_a;
			strap_b_r <= media_id_valid_strap_b;
			function_control_reg_r <= media_id_valid_strap_a;
		end
		else if (wr_fcr)
			function_control_reg_r <= reg_wdata[fdp_pkg::FCR_MSENSE];
	end

	// software control registers
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_r <= fdp_pkg::CTRL_RST;
			tape_sel_r <= fdp_pkg::TAPE_SEL_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= reg_wdata;
			if (wr_tape)
				tape_sel_r <= reg_wdata[1:0];
		end
	end

	// serializer registers
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r <= fdp_pkg::SER_IDLE;
			cnt_r <= 8'h00;
			bitn_r <= 3'h0;
			shift_r <= 8'h00;
			prev_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			if (state_r == fdp_pkg::SER_BIT && cell_end)
			begin
				bitn_r <= bitn_r + 3'h1;
				prev_r <= shift_r[7];
			end
			else if (state_r == fdp_pkg::SER_IDLE)
			begin
				bitn_r <= 3'h0;
				prev_r <= 1'b0;
			end
		end
	end

	// output flops, gate low from reset on
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			reg_rdata <= fdp_pkg::RDATA_IDLE;
			drv_out <= '0;
			alt_out <= '0;
		end
		else
		begin
			reg_rdata <= rdata_nxt;
			drv_out <= {wdata_nxt, floppy_write_enable_gate_nxt, step_req};
			alt_out <= ppm_en ? {wdata_nxt, floppy_write_enable_gate_nxt, step_req} : 3'h0;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	wire rd_tape = reg_rd && (reg_addr == fdp_pkg::ADDR_TAPE) && cap_done_r;

	property p_drv0_low;
		@(posedge mclk) disable iff (!nrst)
		rd_tape && !drv_sel && !function_control_reg_r && !strap_a_r |=> !reg_rdata[5];
	endproperty
	a_drv0_low: assert property (p_drv0_low) else $error("drive 0 valid bit not 0");

	property p_drv0_high;
		@(posedge mclk) disable iff (!nrst)
		rd_tape && !drv_sel && strap_a_r |=> reg_rdata[5];
	endproperty
	a_drv0_high: assert property (p_drv0_high) else $error("drive 0 valid bit not 1");

	property p_drv1;
		@(posedge mclk) disable iff (!nrst)
		rd_tape && drv_sel && !function_control_reg_r |=> reg_rdata[5] == $past(strap_b_r);
	endproperty
	a_drv1: assert property (p_drv1) else $error("drive 1 valid bit wrong");

	property p_fcr_load;
		@(posedge mclk) disable iff (!nrst)
		!cap_done_r |=> function_control_reg_r == $past(media_id_valid_strap_a) && cap_done_r;
	endproperty
	a_fcr_load: assert property (p_fcr_load) else $error("control bit 0 not loaded from strap");

	property p_msense;
		@(posedge mclk) disable iff (!nrst)
		rd_tape && function_control_reg_r |=> reg_rdata[5];
	endproperty
	a_msense: assert property (p_msense) else $error("valid bit not forced when control bit 0 set");

	property p_pulse;
		@(posedge mclk) disable iff (!nrst)
		$rose(drv_out.wdata) |-> drv_out.wdata[*8] ##0 $past(shift_r[7], 8);
	endproperty
	a_pulse: assert property (p_pulse) else $error("write pulse short or not from a one bit");

	property p_gate;
		@(posedge mclk) disable iff (!nrst)
		drv_out.wdata |-> drv_out.floppy_write_enable_gate;
	endproperty
	a_gate: assert property (p_gate) else $error("write data outside write gate");

	property p_alt;
		@(posedge mclk) disable iff (!nrst)
		ppm_en |=> alt_out == drv_out;
	endproperty
	a_alt: assert property (p_alt) else $error("alternate pins differ in floppy port mode");

	property p_alt_off;
		@(posedge mclk) disable iff (!nrst)
		!ppm_en |=> alt_out == 3'h0;
	endproperty
	a_alt_off: assert property (p_alt_off) else $error("alternate pins active outside floppy port mode");

endmodule // fdp_top

// ### tb/fdp_drive_model.sv
`timescale 1ns/1ps

// ****
// floppy drive on the cable
// ****
module fdp_drive_model #(
	parameter logic [1:0] MEDIA = 2'h2
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic wp_on,
	input wire fdp_pkg::fdp_drv_out_t drv_out,
	output fdp_pkg::fdp_drv_in_t drv_in,
	output int n_pulse,
	output int n_gate,
	output int first_gap
);
	logic [7:0] pos_r;
	int gap_r;
	logic seen_r;
	logic step_d;
	logic wd_d;
	logic gate_d;
	// pins seen by the controller
	assign drv_in.wp = wp_on;
	assign drv_in.head_at_first_track = (pos_r == 8'h00);
	assign drv_in.media_id = MEDIA;
	// head moves one track out per step; counts pulses and gate rises
	// first_gap: edges from gate rise to the first write pulse of that gate
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			pos_r <= 8'h01;
			step_d <= 1'b0;
			wd_d <= 1'b0;
			gate_d <= 1'b0;
			n_pulse <= 0;
			n_gate <= 0;
			first_gap <= 0;
			gap_r <= 0;
			seen_r <= 1'b0;
		end
		else
		begin
			step_d <= drv_out.step;
			wd_d <= drv_out.wdata;
			gate_d <= drv_out.floppy_write_enable_gate;
			if (drv_out.step && !step_d && pos_r != 8'h00)
				pos_r <= pos_r - 8'h01;
			if (drv_out.wdata && !wd_d && drv_out.floppy_write_enable_gate)
			begin
				n_pulse <= n_pulse + 1;
				if (!seen_r)
					first_gap <= gap_r;
				seen_r <= 1'b1;
			end
			if (drv_out.floppy_write_enable_gate && !gate_d)
			begin
				n_gate <= n_gate + 1;
				gap_r <= 1;
				seen_r <= 1'b0;
			end
			else
				gap_r <= gap_r + 1;
		end
	end
endmodule // fdp_drive_model

// ### tb/test_fdp_top.sv
`timescale 1ns/1ps

// ****
// register and drive pin bench
// ****
module test_fdp_top;
	logic mclk, nrst, reg_wr, reg_rd, strap_a, strap_b, step_req, wp_on;
	logic [9:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	fdp_pkg::fdp_drv_in_t drv_in;
	fdp_pkg::fdp_alt_in_t alt_in;
	fdp_pkg::fdp_drv_out_t drv_out, alt_out;
	int n_errors, compares, n_pulse, n_gate, exp_p, first_gap;
	logic [7:0] bytes [9] = '{8'hff, 8'h00, 8'ha5, 8'h81, 8'h7e, 8'h01, 8'h80, 8'h3c, 8'hff};

	fdp_top DUT (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .media_id_valid_strap_a(strap_a),
		.media_id_valid_strap_b(strap_b), .step_req(step_req), .drv_in(drv_in), .alt_in(alt_in),
		.drv_out(drv_out), .alt_out(alt_out));
	fdp_drive_model u_drive (.mclk(mclk), .nrst(nrst), .wp_on(wp_on), .drv_out(drv_out), .drv_in(drv_in),
		.n_pulse(n_pulse), .n_gate(n_gate), .first_gap(first_gap));

	// clock
	always #4 mclk = ~mclk;

	task stop_test;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// one-cycle register strobes
	task wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [9:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task rchk(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
		rd(a);
		chk(d & m, e);
	endtask

	task do_reset(input logic a, input logic b);
		@(posedge mclk);
		nrst <= 1'b0;
		strap_a <= a;
		strap_b <= b;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask

	task step_pulse;
		@(posedge mclk);
		step_req <= 1'b1;
		@(posedge mclk);
		step_req <= 1'b0;
		#1;
	endtask

	// poll status until the buffer is empty and the serializer idle
	task drain;
		for (int i = 0; i < 400; i++)
		begin
			repeat (50) @(posedge mclk);
			rd(fdp_pkg::ADDR_STAT);
			if (d[1] === 1'b1 && d[3] === 1'b0)
				break;
		end
		chk(d & 8'h0a, 8'h02);
	endtask

	// watchdog
	initial
	begin
		#400000;
		n_errors++;
		stop_test;
	end

	// test sequence
	initial
	begin
		mclk = 1'b0;
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 10'h000;
		reg_wdata = 8'h00;
		strap_a = 1'b0;
		strap_b = 1'b0;
		step_req = 1'b0;
		wp_on = 1'b0;
		alt_in = '0;
		exp_p = 0;
		for (int i = 0; i < 8; i++)
			exp_p += $countones(bytes[i]);
		do_reset(1'b0, 1'b1);
		rchk(fdp_pkg::ADDR_TAPE, 8'hff, 8'h80);
		wr(fdp_pkg::ADDR_CTRL, 8'h01);
		rchk(fdp_pkg::ADDR_TAPE, 8'hff, 8'ha0);
		rchk(fdp_pkg::ADDR_FCR, 8'h01, 8'h00);
		rchk(10'h3e0, 8'hff, 8'h00);
		wr(fdp_pkg::ADDR_TAPE, 8'hff);
		rchk(fdp_pkg::ADDR_TAPE, 8'h3f, 8'h23);
		do_reset(1'b1, 1'b0);
		rchk(fdp_pkg::ADDR_TAPE, 8'hff, 8'ha0);
		rchk(fdp_pkg::ADDR_FCR, 8'h01, 8'h01);
		wr(fdp_pkg::ADDR_CTRL, 8'h01);
		rchk(fdp_pkg::ADDR_TAPE, 8'hff, 8'ha0);
		wr(fdp_pkg::ADDR_FCR, 8'h00);
		rchk(fdp_pkg::ADDR_TAPE, 8'hff, 8'h80);
		wr(fdp_pkg::ADDR_CTRL, 8'h00);
		rchk(fdp_pkg::ADDR_TAPE, 8'hff, 8'ha0);
		// stepping and track zero, then the alternate pins
		rchk(fdp_pkg::ADDR_STAT, 8'h10, 8'h00);
		step_pulse;
		chk({drv_out.step, alt_out.step}, 2'b10);
		rchk(fdp_pkg::ADDR_STAT, 8'h10, 8'h10);
		wr(fdp_pkg::ADDR_CTRL, 8'h10);
		step_pulse;
		chk({drv_out.step, alt_out.step}, 2'b11);
		alt_in.wp <= 1'b1;
		rchk(fdp_pkg::ADDR_STAT, 8'h11, 8'h01);
		alt_in.wp <= 1'b0;
		wr(fdp_pkg::ADDR_CTRL, 8'h30);
		step_pulse;
		chk({drv_out.step, alt_out.step}, 2'b10);
		// fill the buffer behind write protect, then let it drain
		@(posedge mclk);
		wp_on <= 1'b1;
		wr(fdp_pkg::ADDR_CTRL, 8'h0c);
		for (int i = 0; i < 9; i++)
			wr(fdp_pkg::ADDR_FIFO, bytes[i]);
		rchk(fdp_pkg::ADDR_STAT, 8'h0f, 8'h05);
		chk(n_gate, 0);
		@(posedge mclk);
		wp_on <= 1'b0;
		drain;
		chk(n_pulse, exp_p);
		chk(first_gap, fdp_pkg::PC_BASE_CYC + 1 - 2 * fdp_pkg::PC_STEP_CYC);
		chk(n_gate, 1);
		chk(drv_out.floppy_write_enable_gate, 1'b0);
		// heaviest precompensation on a lone byte
		wr(fdp_pkg::ADDR_CTRL, 8'h0e);
		wr(fdp_pkg::ADDR_FIFO, 8'hc0);
		drain;
		chk(n_pulse, exp_p + 2);
		chk(first_gap, fdp_pkg::PC_BASE_CYC + 1 - 3 * fdp_pkg::PC_STEP_CYC);
		chk(n_gate, 2);
		chk(drv_out.floppy_write_enable_gate, 1'b0);
		stop_test;
	end
endmodule // test_fdp_top
